/* rtl/ssc_defs.vh */
`ifndef SSC_DEFS_VH
`define SSC_DEFS_VH

// Clock period of i_clock in ns (10 MHz)
`define SSC_CLK_PERIOD_NS 100
// Conversion time for all channels, in ns
`define SSC_T_CONV_NS 4000
// Conversion time in clock cycles, rounded down, never below one
`define SSC_CONV_CYCLES ((`SSC_T_CONV_NS / `SSC_CLK_PERIOD_NS) < 1 ? 1 : \
	(`SSC_T_CONV_NS / `SSC_CLK_PERIOD_NS))
// Span settling time after a span change, in ns (host obligation)
`define SSC_T_SPAN_SETTLE_NS 80000

// Channel count and result width
`define SSC_NUM_CH 8
`define SSC_CODE_W 18
// Codes per full scale range: one LSB is FSR over this figure
`define SSC_CODES_PER_FSR 262144

// Controller states
`define SSC_ST_IDLE 1'h0
`define SSC_ST_CONV 1'h1

// Reset values
`define SSC_RST_BUSY 1'h0
`define SSC_RST_SPAN 1'h0
`define SSC_RST_REF 1'h0

`endif

/* rtl/ssc_conv_ctrl.v */
// Summary of operation
// - span input high wide, low narrow
// - sample_start rise holds all channels together
// - busy rises on sample_start rising edge
// - internal clocking, full conversion four microseconds; longer while a full buffer stalls the channel steps
// - busy falls after all eight channels
// - busy fall returns channels to track
// - new o_result set after busy, old during; o_data streams each channel's new result as its step ends
// - results coded twos complement
// - one LSB is FSR over 262144
// - reference select high enables internal reference
// - reference mode taken from select once, on the first edge after reset, then held
`timescale 1ns/1ps
`include "ssc_defs.vh"

module ssc_conv_ctrl #(
	parameter NUM_CH = `SSC_NUM_CH,
	parameter CODE_W = `SSC_CODE_W,
	parameter CH_W   = 3
) (
	input  wire                     i_clock,
	input  wire                     i_resetn,
	input  wire                     i_sample_start,
	input  wire                     i_span_wide,
	input  wire                     i_ref_internal_sel,
	input  wire [NUM_CH*CODE_W-1:0] i_core_code,
	input  wire                     i_data_ready,
	output wire                     o_busy,
	output wire [NUM_CH-1:0]        o_hold,
	output wire                     o_span_wide,
	output wire                     o_ref_internal_en,
	output wire [NUM_CH*CODE_W-1:0] o_result,
	output wire                     o_data_valid,
	output wire [CH_W-1:0]          o_data_channel,
	output wire [CODE_W-1:0]        o_data
);

	// Full-width figures first, then cut on purpose to the counter widths
	localparam integer CONV_CYC_I = `SSC_CONV_CYCLES;  // Whole conversion, full width
	localparam [7:0]   CONV_CYC   = CONV_CYC_I[7:0];   // Whole conversion
	localparam integer CH_CYC_I   = CONV_CYC / NUM_CH; // One channel step, full width
	localparam [7:0]   CH_CYC     = CH_CYC_I[7:0];     // One channel step
	localparam [7:0]   CH_CYC_M1  = CH_CYC - 8'h01;    // Last cycle of a step
	localparam integer LAST_CH_I  = NUM_CH - 1;        // Final channel, full width
	localparam [CH_W-1:0] LAST_CH = LAST_CH_I[CH_W-1:0]; // Final channel index
	localparam BUF_W = CH_W + CODE_W;               // Buffer entry width

	reg                     state_q;          // Controller state
	reg                     state_d;          // Next state
	reg                     start_prev_q;     // Last sample_start level
	reg                     busy_q;           // Busy flag
	reg  [NUM_CH-1:0]       hold_q;           // Track-and-hold control
	reg  [7:0]              step_cnt_q;       // Cycles within a channel step
	reg  [CH_W-1:0]         ch_idx_q;         // Channel being converted
	reg                     span_wide_q;      // Applied input span
	reg                     ref_int_q;        // Internal reference enable
	reg                     cfg_load_q;       // Set during reset, loads config
	reg  [NUM_CH*CODE_W-1:0] sampled_q;      // Held codes at sampling instant
	reg  [NUM_CH*CODE_W-1:0] work_q;         // Results of conversion in flight
	reg  [NUM_CH*CODE_W-1:0] result_q;       // Output register for the host

	// Two-entry output buffer
	reg  [BUF_W-1:0]        buf_mem_q [0:1];  // Storage
	reg                     buf_wr_ptr_q;     // Write slot
	reg                     buf_rd_ptr_q;     // Read slot
	reg  [1:0]              buf_cnt_q;        // Entries held

	wire                    start_rise;       // Qualified sampling edge
	wire                    step_done;        // Channel step ends this cycle
	wire                    buf_full;         // No free slot
	wire                    buf_push;         // Entry written
	wire                    buf_pop;          // Entry taken by receiver
	wire                    conv_last;        // Final channel finishes
	wire [CODE_W-1:0]       cur_code;         // Offset code of current channel
	wire [CODE_W-1:0]       cur_twos;         // Twos complement of it

	// Edge seen only while idle, so a running conversion is never restarted
	assign start_rise = i_sample_start & ~start_prev_q & ~busy_q;

	// A full buffer freezes the step counter, so a stalled receiver loses nothing
	assign buf_full  = (buf_cnt_q == 2'h2);
	assign step_done = (state_q == `SSC_ST_CONV) && (step_cnt_q == CH_CYC_M1) && ~buf_full;
	assign buf_push  = step_done;
	assign buf_pop   = (buf_cnt_q != 2'h0) & i_data_ready;
	assign conv_last = step_done && (ch_idx_q == LAST_CH);

	// Core delivers offset binary over 2^CODE_W codes of FSR; MSB flip gives
	// twos complement with the same half-LSB transition points
	assign cur_code = sampled_q[ch_idx_q*CODE_W +: CODE_W];
	assign cur_twos = {~cur_code[CODE_W-1], cur_code[CODE_W-2:0]};

	// Sampling edge detector
	always @(posedge i_clock) begin
		if (!i_resetn) begin
			start_prev_q <= 1'h0;
		end else begin
			start_prev_q <= i_sample_start;
		end
	end

	// Next-state logic
	always @* begin
		state_d = state_q;
		case (state_q)
			`SSC_ST_IDLE: begin
				if (start_rise) begin
					state_d = `SSC_ST_CONV;
				end
			end
			`SSC_ST_CONV: begin
				if (conv_last) begin
					state_d = `SSC_ST_IDLE;
				end
			end
			default: begin
				state_d = `SSC_ST_IDLE;
			end
		endcase
	end

	// Control sequencer: busy, hold and channel stepping
	always @(posedge i_clock) begin
		if (!i_resetn) begin
			state_q    <= `SSC_ST_IDLE;
			busy_q     <= `SSC_RST_BUSY;
			hold_q     <= {NUM_CH{1'h0}};
			step_cnt_q <= 8'h00;
			ch_idx_q   <= {CH_W{1'h0}};
		end else begin
			state_q <= state_d;
			if (start_rise) begin
				// All channels into hold on the same edge
				hold_q     <= {NUM_CH{1'h1}};
				busy_q     <= 1'h1;
				step_cnt_q <= 8'h00;
				ch_idx_q   <= {CH_W{1'h0}};
			end else if (conv_last) begin
				// Busy falls and tracking resumes together
				busy_q <= 1'h0;
				hold_q <= {NUM_CH{1'h0}};
			end else if (step_done) begin
				step_cnt_q <= 8'h00;
				ch_idx_q   <= ch_idx_q + {{(CH_W-1){1'h0}}, 1'h1};
			end else if (state_q == `SSC_ST_CONV && step_cnt_q != CH_CYC_M1) begin
				// Internal conversion clock: step length totals CONV_CYC
				step_cnt_q <= step_cnt_q + 8'h01;
			end
		end
	end

	// Per channel: sample capture, result accumulation and output copy
	genvar g;
	generate
		for (g = 0; g < NUM_CH; g = g + 1) begin : g_ch
			always @(posedge i_clock) begin
				if (!i_resetn) begin
					sampled_q[g*CODE_W +: CODE_W] <= {CODE_W{1'h0}};
					work_q[g*CODE_W +: CODE_W]    <= {CODE_W{1'h0}};
					result_q[g*CODE_W +: CODE_W]  <= {CODE_W{1'h0}};
				end else begin
					// Value frozen at the hold instant
					if (start_rise) begin
						sampled_q[g*CODE_W +: CODE_W] <= i_core_code[g*CODE_W +: CODE_W];
					end
					if (step_done && ch_idx_q == g) begin
						work_q[g*CODE_W +: CODE_W] <= cur_twos;
					end
					// Previous set stays readable until busy falls
					if (conv_last) begin
						result_q[g*CODE_W +: CODE_W] <= (g == NUM_CH - 1) ? cur_twos :
							work_q[g*CODE_W +: CODE_W];
					end
				end
			end
		end
	endgenerate

	// Span follows its input one cycle later; reference mode is taken after reset
	always @(posedge i_clock) begin
		if (!i_resetn) begin
			span_wide_q <= `SSC_RST_SPAN;
			ref_int_q   <= `SSC_RST_REF;
			cfg_load_q  <= 1'h1;
		end else begin
			span_wide_q <= i_span_wide;
			cfg_load_q  <= 1'h0;
			// Caught on the first edge after release, not by the reset itself
			if (cfg_load_q) begin
				ref_int_q <= i_ref_internal_sel;
			end
		end
	end

	// Two-entry buffer in the result stream
	always @(posedge i_clock) begin
		if (!i_resetn) begin
			buf_wr_ptr_q <= 1'h0;
			buf_rd_ptr_q <= 1'h0;
			buf_cnt_q    <= 2'h0;
			buf_mem_q[0] <= {BUF_W{1'h0}};
			buf_mem_q[1] <= {BUF_W{1'h0}};
		end else begin
			if (buf_push) begin
				buf_mem_q[buf_wr_ptr_q] <= {ch_idx_q, cur_twos};
				buf_wr_ptr_q            <= ~buf_wr_ptr_q;
			end
			if (buf_pop) begin
				buf_rd_ptr_q <= ~buf_rd_ptr_q;
			end
			// Count tracks push and pop in the same cycle
			case ({buf_push, buf_pop})
				2'h2:    buf_cnt_q <= buf_cnt_q + 2'h1;
				2'h1:    buf_cnt_q <= buf_cnt_q - 2'h1;
				default: buf_cnt_q <= buf_cnt_q;
			endcase
		end
	end

	// Output drive
	assign o_busy            = busy_q;
	assign o_hold            = hold_q;
	assign o_span_wide       = span_wide_q;
	assign o_ref_internal_en = ref_int_q;
	assign o_result          = result_q;
	assign o_data_valid      = (buf_cnt_q != 2'h0);
	assign o_data_channel    = buf_mem_q[buf_rd_ptr_q][BUF_W-1:CODE_W];
	assign o_data            = buf_mem_q[buf_rd_ptr_q][CODE_W-1:0];

endmodule

/* tb/ssc_checker.sv */
`timescale 1ns/1ps
module ssc_checker #(parameter NUM_CH = 8, parameter CODE_W = 18, parameter CH_W = 3) (
	input wire                     i_clock,
	input wire                     i_resetn,
	input wire                     i_sample_start,
	input wire                     i_span_wide,
	input wire                     i_data_ready,
	input wire                     o_busy,
	input wire [NUM_CH-1:0]        o_hold,
	input wire                     o_span_wide,
	input wire                     o_ref_internal_en,
	input wire [NUM_CH*CODE_W-1:0] o_result,
	input wire                     o_data_valid,
	input wire [CH_W-1:0]          o_data_channel,
	input wire [CODE_W-1:0]        o_data
);
	int busy_cnt_q; // Busy cycles in the current set
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_resetn);
	// Counter clears whenever busy is low
	always @(posedge i_clock) busy_cnt_q <= (!i_resetn || !o_busy) ? 0 : busy_cnt_q + 1;
	property p_busy_rise; $rose(i_sample_start) && !o_busy |=> o_busy; endproperty
	a_busy_rise: assert property (p_busy_rise) else $error("busy missed start");
	property p_hold_all; o_hold == {NUM_CH{o_busy}}; endproperty
	a_hold_all: assert property (p_hold_all) else $error("hold not with busy");
	property p_conv_len; $fell(o_busy) && $past(i_resetn) |-> busy_cnt_q >= 40; endproperty
	a_conv_len: assert property (p_conv_len) else $error("conversion too short");
	property p_conv_end; $rose(o_busy) |-> ##[1:1000] !o_busy; endproperty
	a_conv_end: assert property (p_conv_end) else $error("busy never fell");
	property p_result_hold; o_busy && $past(o_busy) |-> $stable(o_result); endproperty
	a_result_hold: assert property (p_result_hold) else $error("result moved");
	property p_word_stands;
		o_data_valid && !i_data_ready |=> o_data_valid && $stable(o_data) && $stable(o_data_channel);
	endproperty
	a_word_stands: assert property (p_word_stands) else $error("word lost");
	property p_span; $past(i_resetn) |-> o_span_wide == $past(i_span_wide); endproperty
	a_span: assert property (p_span) else $error("span not applied");
	property p_ref_keep;
		$past(i_resetn, 3) && $past(i_resetn, 2) && $past(i_resetn) |-> $stable(o_ref_internal_en);
	endproperty
	a_ref_keep: assert property (p_ref_keep) else $error("reference mode moved");
	cover property ($fell(o_busy));
	cover property (o_data_valid && !i_data_ready);
	cover property ($rose(i_sample_start) && o_busy);
endmodule
bind ssc_conv_ctrl ssc_checker #(.NUM_CH(NUM_CH), .CODE_W(CODE_W), .CH_W(CH_W)) u_chk (
	.i_clock(i_clock), .i_resetn(i_resetn), .i_sample_start(i_sample_start),
	.i_span_wide(i_span_wide), .i_data_ready(i_data_ready), .o_busy(o_busy), .o_hold(o_hold),
	.o_span_wide(o_span_wide), .o_ref_internal_en(o_ref_internal_en), .o_result(o_result),
	.o_data_valid(o_data_valid), .o_data_channel(o_data_channel), .o_data(o_data));

/* tb/ssc_host_model.sv */
`timescale 1ns/1ps
module ssc_host_model (
	input  wire logic        i_clock,
	input  wire logic        i_stall,
	input  wire logic        i_valid,
	input  wire logic [2:0]  i_channel,
	input  wire logic [17:0] i_data,
	output logic             o_ready
);
	logic [17:0] words [8]; // Last word seen per channel
	int          count = 0; // Words taken so far
	logic [2:0]  tick  = 0; // Slow reader is ready one cycle in eight
	initial o_ready = 1'b0;
	// Reads the stream; a slow host stalls the buffer
	always @(posedge i_clock) begin
		tick <= tick + 3'h1;
		if (i_valid && o_ready) begin
			words[i_channel] <= i_data;
			count <= count + 1;
		end
		o_ready <= !i_stall || tick == 3'h0;
	end
endmodule

/* tb/test_simultaneous_sample_conversion_control.sv */
`timescale 1ns/1ps
module test_simultaneous_sample_conversion_control;
	logic clk = 0, rstn = 0, start = 0, span = 0, rsel = 0, stall = 0, rdy, busy, spo, ren, vld;
	logic [143:0] core = 0, res;
	logic [7:0] hold;
	logic [2:0] ch;
	logic [17:0] dat;
	int bad_count = 0, total_checks = 0;
	always #50 clk = ~clk;
	ssc_conv_ctrl i_dut (.i_clock(clk), .i_resetn(rstn), .i_sample_start(start),
		.i_span_wide(span), .i_ref_internal_sel(rsel), .i_core_code(core), .i_data_ready(rdy),
		.o_busy(busy), .o_hold(hold), .o_span_wide(spo), .o_ref_internal_en(ren), .o_result(res),
		.o_data_valid(vld), .o_data_channel(ch), .o_data(dat));
	ssc_host_model i_model (.i_clock(clk), .i_stall(stall), .i_valid(vld), .i_channel(ch),
		.i_data(dat), .o_ready(rdy));
	task check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task summarize;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// Reset with a given reference select, then check the latched mode
	task reset_ref(input logic sel);
		rsel = sel;
		rstn = 0;
		cyc(2);
		rstn = 1;
		cyc(3);
		check(ren, sel);
	endtask
	// Span applied one cycle after the input moves
	task span_flip;
		span = 1;
		cyc(1);
		check(spo, 1);
		span = 0;
		cyc(1);
		check(spo, 0);
	endtask
	// One full set; a second start mid-run must not restart it
	task conv(input logic [17:0] base, input logic slow);
		int n, k, got;
		stall = slow;
		got = i_model.count;
		for (k = 0; k < 8; k++) core[k*18+:18] = base + 18'(k);
		start = 1;
		cyc(1);
		start = 0;
		n = 1;
		while (busy === 1'b1 && n < 2000) begin
			if (n == 5) check(hold, 8'hff);
			start = (n == 10); // Edge while busy must be ignored
			cyc(1);
			n++;
		end
		if (n == 2000) begin
			bad_count++;
			summarize();
		end
		if (!slow) check(n - 1, 40);
		else check(n > 41, 1);
		check(hold, 8'h00);
		for (k = 0; k < 8; k++) check(res[k*18+:18], (base + 18'(k)) ^ 18'h20000);
		for (n = 0; n < 40 && i_model.count < got + 8; n++) cyc(1);
		check(i_model.count, got + 8);
		for (k = 0; k < 8; k++) check(i_model.words[k], (base + 18'(k)) ^ 18'h20000);
	endtask
	initial begin
		reset_ref(1); // Power-up reset before any sampling
		span_flip();
		cyc(800); // Span settling of 80 us before the next sample
		conv(18'h00000, 0);
		conv(18'h1fffc, 1);
		conv(18'h3fff8, 0);
		reset_ref(0);
		conv(18'h1fffc, 0);
		summarize();
	end
endmodule
